// ===== hdl/cmf_pkg.sv
// Shared constants of the CAN message buffer and acceptance filter block.
package cmf_pkg;

    // Slot geometry: thirteen bytes per receive slot and per transmit buffer.
    localparam int CMF_SLOT_BYTES = 13;
    localparam int CMF_SLOT_BITS = 8 * CMF_SLOT_BYTES;
    localparam int CMF_NUM_TX = 3;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] CMF_RX_FLAG_OFS = 8'h00;
    localparam logic [7:0] CMF_CTRL_OFS = 8'h04;
    localparam logic [7:0] CMF_TX_FLAG_OFS = 8'h08;
    localparam logic [7:0] CMF_TX_CTRL_OFS = 8'h0C;
    localparam logic [7:0] CMF_PATTERN_OFS = 8'h10;
    localparam logic [7:0] CMF_MASK_OFS = 8'h14;
    localparam logic [2:0] CMF_RX_SLOT_PAGE = 3'h1;
    localparam logic [2:0] CMF_TX_BUF_PAGE = 3'h2;
    localparam logic [2:0] CMF_PRIORITY_WORD = 3'h4;

    // Field positions of the receive flag register.
    localparam int CMF_RX_FULL_BIT = 0;
    localparam int CMF_OVR_BIT = 1;
    localparam int CMF_HIT_LSB = 4;

    // Field positions of the control register.
    localparam int CMF_LOOPBACK_BIT = 0;
    localparam int CMF_MODE_LSB = 1;
    localparam int CMF_RXIE_BIT = 3;
    localparam int CMF_OVRIE_BIT = 4;

    // Field positions of the transmit flag and transmit control registers.
    localparam int CMF_TX_EMPTY_LSB = 0;
    localparam int CMF_ABORT_ACK_LSB = 4;
    localparam int CMF_ABORT_REQ_LSB = 0;
    localparam int CMF_TXIE_LSB = 4;

    // Filter mode encodings.
    localparam logic [1:0] CMF_MODE_SINGLE = 2'h0;
    localparam logic [1:0] CMF_MODE_DUAL = 2'h1;
    localparam logic [1:0] CMF_MODE_QUAD = 2'h2;
    localparam logic [1:0] CMF_MODE_CLOSED = 2'h3;

    // Reset values.
    localparam logic [1:0] CMF_MODE_RST = CMF_MODE_CLOSED;
    localparam logic [2:0] CMF_TX_EMPTY_RST = 3'h7;
    localparam logic [31:0] CMF_FILTER_RST = 32'h0000_0000;

endpackage

// ===== hdl/cmf_msg_buffer_filter.sv
`timescale 1ns/10ps
module cmf_msg_buffer_filter
    import cmf_pkg::*;
#(
    parameter int NUM_TX = CMF_NUM_TX
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CAN transceiver pins.
    input wire logic bus_rx_pin,
    output logic bus_tx_pin,
    // Bit level to and from the protocol engine.
    input wire logic eng_tx_dominant,
    output logic rx_bit_dominant,
    output logic loopback_mode,
    // Received byte stream from the protocol engine.
    input wire logic eng_rx_sof,
    input wire logic eng_rx_byte_valid,
    input wire logic [3:0] eng_rx_byte_idx,
    input wire logic [7:0] eng_rx_byte,
    input wire logic eng_rx_eof,
    input wire logic eng_rx_ok,
    // Transmit scheduling with the protocol engine.
    input wire logic eng_arb_req,
    input wire logic eng_arb_lost,
    input wire logic eng_tx_err,
    input wire logic eng_tx_done,
    input wire logic [3:0] eng_tx_byte_idx,
    output logic tx_pending,
    output logic [1:0] tx_buf_sel,
    output logic [7:0] tx_byte,
    // Interrupt levels.
    output logic rx_irq,
    output logic tx_irq,
    output logic err_irq
);

    // True when every unmasked, relevant bit of id equals the pattern bit.
    function automatic logic match8(input logic [7:0] id, input logic [7:0] pat,
                                    input logic [7:0] msk, input logic [7:0] care);
        match8 = (((id ^ pat) & ~msk & care) == 8'h00);
    endfunction

    // Receive storage: background slot for the controller, foreground for the host.
    logic [CMF_SLOT_BITS-1:0] bg_slot; // Frame being received.
    logic [CMF_SLOT_BITS-1:0] foreground_rx_slot; // Frame visible to the host.
    logic rx_full_flag; // Foreground holds an accepted frame.
    logic bg_pending; // Background holds an accepted frame awaiting copy.
    logic [1:0] bg_hit; // Hit index of the pending background frame.
    logic [1:0] filter_hit_index; // Hit index of the foreground frame.
    logic overrun_flag; // An accepted frame was lost.
    logic own_frame; // The frame on the bus is our own transmission.

    // Configuration registers.
    logic [1:0] filter_mode; // Acceptance filter mode.
    logic rx_ie; // Receive interrupt enable.
    logic ovr_ie; // Overrun interrupt enable.
    logic [31:0] acceptance_pattern_regs; // Four pattern bytes.
    logic [31:0] acceptance_mask_regs; // Four mask bytes, one means don't care.

    // Transmit storage and flags.
    logic [CMF_SLOT_BITS-1:0] tx_buf [NUM_TX]; // Transmit buffers.
    logic [7:0] tx_priority_reg [NUM_TX]; // Local priority per buffer.
    logic [NUM_TX-1:0] tx_empty_flag; // Buffer free for the host.
    logic [NUM_TX-1:0] abort_request_bit; // Host wants the buffer back.
    logic [NUM_TX-1:0] abort_ack_flag; // Buffer was released by abort.
    logic [NUM_TX-1:0] tx_ie; // Transmit interrupt enables.

    // APB phase decode.
    wire bus_setup = psel & ~penable;
    wire bus_access = psel & penable & pready;
    wire bus_wr = bus_access & pwrite;
    wire [2:0] page = paddr[7:5];
    wire [2:0] word = paddr[4:2];
    wire [2:0] tx_page = page - CMF_TX_BUF_PAGE;
    wire is_rx_slot = (page == CMF_RX_SLOT_PAGE) && (word < 3'h4);
    wire is_tx_buf = (page >= CMF_TX_BUF_PAGE) && (tx_page < 3'(NUM_TX)) &&
                     (word <= CMF_PRIORITY_WORD);
    wire [1:0] tx_idx = tx_page[1:0];
    wire wr_rxflag = bus_wr && (paddr == CMF_RX_FLAG_OFS);
    wire wr_ctrl = bus_wr && (paddr == CMF_CTRL_OFS);
    wire wr_txflag = bus_wr && (paddr == CMF_TX_FLAG_OFS);
    wire wr_txctrl = bus_wr && (paddr == CMF_TX_CTRL_OFS);
    wire wr_pattern = bus_wr && (paddr == CMF_PATTERN_OFS);
    wire wr_mask = bus_wr && (paddr == CMF_MASK_OFS);
    wire wr_txbuf = bus_wr && is_tx_buf;

    // Read data mux, evaluated in the setup cycle and registered for access.
    logic [31:0] rd_word;
    logic rd_hit;
    // Slots padded to four whole words so the word-wide read path stays in range.
    wire [127:0] fg_words = {24'h00_0000, foreground_rx_slot};
    wire [127:0] tx_words = {24'h00_0000, tx_buf[tx_idx]};
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == CMF_RX_FLAG_OFS) begin
            rd_word[CMF_RX_FULL_BIT] = rx_full_flag;
            rd_word[CMF_OVR_BIT] = overrun_flag;
            rd_word[CMF_HIT_LSB +: 2] = filter_hit_index;
        end else if (paddr == CMF_CTRL_OFS) begin
            rd_word[CMF_LOOPBACK_BIT] = loopback_mode;
            rd_word[CMF_MODE_LSB +: 2] = filter_mode;
            rd_word[CMF_RXIE_BIT] = rx_ie;
            rd_word[CMF_OVRIE_BIT] = ovr_ie;
        end else if (paddr == CMF_TX_FLAG_OFS) begin
            rd_word[CMF_TX_EMPTY_LSB +: NUM_TX] = tx_empty_flag;
            rd_word[CMF_ABORT_ACK_LSB +: NUM_TX] = abort_ack_flag;
        end else if (paddr == CMF_TX_CTRL_OFS) begin
            rd_word[CMF_ABORT_REQ_LSB +: NUM_TX] = abort_request_bit;
            rd_word[CMF_TXIE_LSB +: NUM_TX] = tx_ie;
        end else if (paddr == CMF_PATTERN_OFS) begin
            rd_word = acceptance_pattern_regs;
        end else if (paddr == CMF_MASK_OFS) begin
            rd_word = acceptance_mask_regs;
        end else if (is_rx_slot) begin
            rd_word = fg_words[32*word +: 32];
        end else if (is_tx_buf && word == CMF_PRIORITY_WORD) begin
            rd_word[7:0] = tx_priority_reg[tx_idx];
        end else if (is_tx_buf) begin
            rd_word = tx_words[32*word +: 32];
        end else begin
            rd_hit = 1'b0;
        end
    end

    // APB answer: one access cycle, unmapped addresses give an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= bus_setup;
            pslverr <= bus_setup & ~rd_hit;
            prdata <= (bus_setup && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loopback_mode <= 1'b0;
            filter_mode <= CMF_MODE_RST;
            rx_ie <= 1'b0;
            ovr_ie <= 1'b0;
            tx_ie <= '0;
            acceptance_pattern_regs <= CMF_FILTER_RST;
            acceptance_mask_regs <= CMF_FILTER_RST;
        end else begin
            if (wr_ctrl) begin
                loopback_mode <= pwdata[CMF_LOOPBACK_BIT];
                filter_mode <= pwdata[CMF_MODE_LSB +: 2];
                rx_ie <= pwdata[CMF_RXIE_BIT];
                ovr_ie <= pwdata[CMF_OVRIE_BIT];
            end
            if (wr_txctrl) begin
                tx_ie <= pwdata[CMF_TXIE_LSB +: NUM_TX];
            end
            if (wr_pattern) begin
                acceptance_pattern_regs <= pwdata;
            end
            if (wr_mask) begin
                acceptance_mask_regs <= pwdata;
            end
        end
    end

    // Identifier bytes of the background frame and the filter bank.
    wire [7:0] idr0 = bg_slot[7:0];
    wire [7:0] idr1 = bg_slot[15:8];
    wire [7:0] idr2 = bg_slot[23:16];
    wire [7:0] idr3 = bg_slot[31:24];
    wire ext_frame = idr1[3];
    wire [7:0] care1 = ext_frame ? 8'hFF : 8'hF8;
    wire [7:0] care_ext = ext_frame ? 8'hFF : 8'h00;
    wire [7:0] pb [4];
    wire [7:0] mb [4];
    for (genvar k = 0; k < 4; k++) begin : g_bytes
        assign pb[k] = acceptance_pattern_regs[8*k +: 8];
        assign mb[k] = acceptance_mask_regs[8*k +: 8];
    end
    wire single_hit = match8(idr0, pb[0], mb[0], 8'hFF) &&
                      match8(idr1, pb[1], mb[1], care1) &&
                      match8(idr2, pb[2], mb[2], care_ext) &&
                      match8(idr3, pb[3], mb[3], care_ext);
    wire dual0 = match8(idr0, pb[0], mb[0], 8'hFF) &&
                 match8(idr1, pb[1], mb[1], care1);
    wire dual1 = match8(idr0, pb[2], mb[2], 8'hFF) &&
                 match8(idr1, pb[3], mb[3], care1);
    wire [3:0] quad_hits = {match8(idr0, pb[3], mb[3], 8'hFF),
                            match8(idr0, pb[2], mb[2], 8'hFF),
                            match8(idr0, pb[1], mb[1], 8'hFF),
                            match8(idr0, pb[0], mb[0], 8'hFF)};
    wire [3:0] hits = (filter_mode == CMF_MODE_SINGLE) ? {3'h0, single_hit} :
                      (filter_mode == CMF_MODE_DUAL) ? {2'h0, dual1, dual0} :
                      (filter_mode == CMF_MODE_QUAD) ? quad_hits : 4'h0;
    wire [1:0] hit_enc = hits[0] ? 2'h0 : hits[1] ? 2'h1 :
                         hits[2] ? 2'h2 : 2'h3;

    // A completed frame is accepted only if good, matching and not our own echo unless loop-back is on.
    wire frame_accept = eng_rx_eof && eng_rx_ok && (|hits) &&
                        (!own_frame || loopback_mode);
    wire move_to_fg = bg_pending && !rx_full_flag;
    wire clr_rxf = wr_rxflag && pwdata[CMF_RX_FULL_BIT];
    wire clr_ovr = wr_rxflag && pwdata[CMF_OVR_BIT];

    // Background slot capture; frozen while an accepted frame waits in it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bg_slot <= '0;
        end else if (eng_rx_byte_valid && !bg_pending &&
                     eng_rx_byte_idx < 4'(CMF_SLOT_BYTES)) begin
            bg_slot[8*eng_rx_byte_idx +: 8] <= eng_rx_byte;
        end
    end

    // Own-frame tracking: cleared when arbitration is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_frame <= 1'b0;
        end else if (eng_arb_lost) begin
            own_frame <= 1'b0;
        end else if (eng_rx_sof) begin
            own_frame <= tx_pending;
        end
    end

    // Ping-pong control between background and foreground slots.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bg_pending <= 1'b0;
            bg_hit <= 2'h0;
            rx_full_flag <= 1'b0;
            filter_hit_index <= 2'h0;
            foreground_rx_slot <= '0;
            overrun_flag <= 1'b0;
        end else begin
            // Accepted frame is parked, or dropped as overrun when both slots hold one.
            if (frame_accept && !bg_pending) begin
                bg_pending <= 1'b1;
                bg_hit <= hit_enc;
            end else if (move_to_fg) begin
                bg_pending <= 1'b0;
            end
            // Copy to the foreground only while it is free.
            if (move_to_fg) begin
                foreground_rx_slot <= bg_slot;
                filter_hit_index <= bg_hit;
                rx_full_flag <= 1'b1;
            end else if (clr_rxf) begin
                rx_full_flag <= 1'b0;
            end
            // Overrun: set wins over a simultaneous clear.
            if (frame_accept && bg_pending && rx_full_flag) begin
                overrun_flag <= 1'b1;
            end else if (clr_ovr) begin
                overrun_flag <= 1'b0;
            end
        end
    end

    // Candidate buffers and local-priority selection, ties to the lower index.
    wire [NUM_TX-1:0] tx_ready = ~tx_empty_flag & ~abort_request_bit;
    logic [1:0] best_buf;
    logic any_ready;
    always_comb begin
        best_buf = 2'h0;
        any_ready = 1'b0;
        for (int b = 0; b < NUM_TX; b++) begin
            if (tx_ready[b] && (!any_ready || tx_priority_reg[b] < tx_priority_reg[best_buf])) begin
                best_buf = 2'(b);
                any_ready = 1'b1;
            end
        end
    end

    // Transmit scheduling: reselect on every arbitration entry, retries included.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pending <= 1'b0;
            tx_buf_sel <= 2'h0;
        end else if (eng_arb_req) begin
            tx_pending <= any_ready;
            tx_buf_sel <= best_buf;
        end else if (eng_tx_done || eng_arb_lost || eng_tx_err) begin
            tx_pending <= 1'b0;
        end
    end

    // Per-buffer storage, flags and abort handling.
    for (genvar b = 0; b < NUM_TX; b++) begin : g_tx
        wire on_bus = tx_pending && (tx_buf_sel == 2'(b));
        wire sent = eng_tx_done && on_bus;
        wire abort_grant = abort_request_bit[b] && !tx_empty_flag[b] && !on_bus;
        wire host_sched = wr_txflag && pwdata[CMF_TX_EMPTY_LSB + b] && !on_bus;
        wire host_abort = wr_txctrl && pwdata[CMF_ABORT_REQ_LSB + b];
        wire buf_wr = wr_txbuf && (tx_idx == 2'(b));

        // Buffer contents and local priority written by software.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tx_buf[b] <= '0;
                tx_priority_reg[b] <= 8'h00;
            end else if (buf_wr && word == CMF_PRIORITY_WORD) begin
                tx_priority_reg[b] <= pwdata[7:0];
            end else if (buf_wr && word == 3'h3) begin
                tx_buf[b][CMF_SLOT_BITS-1 -: 8] <= pwdata[7:0];
            end else if (buf_wr) begin
                tx_buf[b][32*word +: 32] <= pwdata;
            end
        end

        // Empty, abort request and acknowledge flags; a send or abort grant wins over host writes.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tx_empty_flag[b] <= CMF_TX_EMPTY_RST[b];
                abort_request_bit[b] <= 1'b0;
                abort_ack_flag[b] <= 1'b0;
            end else begin
                if (sent || abort_grant) begin
                    tx_empty_flag[b] <= 1'b1;
                    abort_request_bit[b] <= 1'b0;
                    abort_ack_flag[b] <= abort_grant;
                end else begin
                    if (host_sched) begin
                        tx_empty_flag[b] <= 1'b0;
                        abort_ack_flag[b] <= 1'b0;
                    end
                    if (host_abort && !tx_empty_flag[b]) begin
                        abort_request_bit[b] <= 1'b1;
                    end
                end
            end
        end
    end

    // Byte fetch for the engine, pins and interrupt levels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_byte <= 8'h00;
            bus_tx_pin <= 1'b1;
            rx_bit_dominant <= 1'b0;
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
            err_irq <= 1'b0;
        end else begin
            tx_byte <= (eng_tx_byte_idx < 4'(CMF_SLOT_BYTES)) ?
                       tx_buf[tx_buf_sel][8*eng_tx_byte_idx +: 8] : 8'h00;
            bus_tx_pin <= ~eng_tx_dominant;
            rx_bit_dominant <= ~bus_rx_pin;
            rx_irq <= rx_full_flag & rx_ie;
            tx_irq <= |(tx_empty_flag & tx_ie);
            err_irq <= overrun_flag & ovr_ie;
        end
    end

    // Checks on the design's own behaviour.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_rx_full_source: assert property ($rose(rx_full_flag) |-> $past(bg_pending) &&
                                        !$past(rx_full_flag))
        else $error("receive-full rose without a parked accepted frame");
    a_accept_parks: assert property (frame_accept && !bg_pending && !rx_full_flag
                                     |=> bg_pending ##1 rx_full_flag ##1 rx_irq || !rx_ie)
        else $error("accepted frame did not reach the foreground in time");
    a_own_not_parked: assert property (eng_rx_eof && own_frame && !loopback_mode
                                       && !bg_pending |=> !bg_pending)
        else $error("own frame was accepted outside loop-back");
    a_overrun_set: assert property (frame_accept && bg_pending && rx_full_flag
                                    |=> overrun_flag && $stable(foreground_rx_slot))
        else $error("overrun not flagged or foreground changed");
    a_closed_never: assert property (filter_mode == CMF_MODE_CLOSED && !bg_pending
                                     |=> !bg_pending)
        else $error("closed filter accepted a frame");
    a_sent_empty: assert property (eng_tx_done && tx_pending
                                   |=> tx_empty_flag[$past(tx_buf_sel)] && !tx_pending)
        else $error("sent buffer not released");
    a_abort_pair: assert property ($rose(abort_ack_flag[0]) |-> tx_empty_flag[0] &&
                                   !$past(tx_empty_flag[0]) && !$past(tx_pending &&
                                   tx_buf_sel == 2'h0))
        else $error("abort acknowledged for a busy or free buffer");
    a_priority_pick: assert property (eng_arb_req && any_ready
                                  |=> tx_pending && !tx_empty_flag[tx_buf_sel] &&
                                  tx_priority_reg[tx_buf_sel] <= $past(tx_priority_reg[0]) ||
                                  $past(tx_empty_flag[0] | abort_request_bit[0]))
        else $error("selected buffer is not the lowest priority value");
    a_tx_pin_level: assert property (##1 bus_tx_pin == !$past(eng_tx_dominant))
        else $error("transmit pin level does not follow the engine");
    a_apb_answer: assert property (bus_setup |=> pready ##1 !pready)
        else $error("APB answer is not a single access cycle");

    c_frame_received: cover property ($rose(rx_full_flag));
    c_overrun: cover property ($rose(overrun_flag));
    c_abort: cover property ($rose(|abort_ack_flag));
    c_sent: cover property (eng_tx_done && tx_pending);

endmodule

// ===== verif/cmf_bus_node_model.sv
`timescale 1ns/10ps
// Remote node: streams one frame, byte by byte, into the receive side on request.
module cmf_bus_node_model (
    // Clock and request from the bench.
    input wire logic pclk,
    input wire logic go,
    input wire logic [103:0] frame,
    output logic busy,
    // Received stream towards the block.
    output logic sof,
    output logic bv,
    output logic [3:0] idx,
    output logic [7:0] data,
    output logic eof
);
    int step = 0; // Position in the frame, zero while idle.
    initial {sof, bv, idx, data, eof} = '0;
    assign busy = go || step != 0;
    // Start mark, thirteen bytes, then the end mark; data toggles when not valid.
    always @(posedge pclk) begin
        if (busy) begin
            step <= (step == 15) ? 0 : step + 1;
        end
        sof <= go;
        bv <= step >= 1 && step <= 13;
        idx <= 4'((step + 15) % 16);
        data <= (step >= 1 && step <= 13) ? frame[8*((step + 12) % 13) +: 8] : ~data;
        eof <= step == 14;
    end
endmodule

// ===== verif/can_msg_buffer_filter_tb.sv
`timescale 1ns/10ps
module can_msg_buffer_filter_tb;
    import cmf_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, eng_tx_dominant = 0;
    logic eng_arb_req = 0, eng_tx_done = 0, pready, pslverr, bus_tx_pin, tx_pending, rx_irq;
    logic busy, sof, bv, eof, rx_dom, tx_irq, err_irq, ok = 1;
    logic [1:0] tx_buf_sel;
    logic [3:0] idx, tbi = 0;
    logic [7:0] paddr = 0, data, tx_byte;
    logic [31:0] pwdata = 0, prdata, seed = 32'hB4E9;
    logic [103:0] frame = 0;
    logic [32:0] q[$]; // Expected {error, read data} of each read, oldest first.
    int mismatches = 0, total_checks = 0, cycles = 0;
    initial forever #4 pclk = ~pclk;
    cmf_msg_buffer_filter u_cmf_msg_buffer_filter (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_rx_pin(bus_tx_pin), .bus_tx_pin(bus_tx_pin),
        .eng_tx_dominant(eng_tx_dominant), .rx_bit_dominant(rx_dom), .loopback_mode(),
        .eng_rx_sof(sof),
        .eng_rx_byte_valid(bv), .eng_rx_byte_idx(idx), .eng_rx_byte(data), .eng_rx_eof(eof),
        .eng_rx_ok(eof & ok), .eng_arb_req(eng_arb_req), .eng_arb_lost(1'b0), .eng_tx_err(1'b0),
        .eng_tx_done(eng_tx_done), .eng_tx_byte_idx(tbi), .tx_pending(tx_pending),
        .tx_buf_sel(tx_buf_sel), .tx_byte(tx_byte), .rx_irq(rx_irq), .tx_irq(tx_irq),
        .err_irq(err_irq));
    cmf_bus_node_model u_cmf_bus_node_model (.pclk(pclk), .go(go), .frame(frame), .busy(busy),
        .sof(sof), .bv(bv), .idx(idx), .data(data), .eof(eof));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; a read leaves its expectation for the monitor.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) q.push_back(exp);
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Has the remote node send one frame, then lets the flag and interrupt settle.
    task automatic send(input logic [103:0] f);
        frame <= f;
        go <= 1;
        @(posedge pclk);
        go <= 0;
        do @(posedge pclk); while (busy);
        repeat (4) @(posedge pclk);
    endtask
    task automatic end_of_test();
        // Reads that never got their answer count together as one mismatch.
        if (q.size() != 0) mismatches++;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Monitor: each completed read is compared with the oldest expectation.
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && q.size() > 0) chk({pslverr, prdata}, q.pop_front());
    end
    // Watchdog: a hang counts as a mismatch.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, CMF_TX_FLAG_OFS, 0, 33'h7);
        apb(0, CMF_CTRL_OFS, 0, 33'h6);
        apb(0, 8'h18, 0, 33'h1_0000_0000);
        send(104'h5A);
        apb(0, CMF_RX_FLAG_OFS, 0, 33'h0);
        $display("reset and closed filter test done");
        seed = xs(seed);
        apb(1, CMF_CTRL_OFS, 32'h8, 0);
        apb(1, CMF_MASK_OFS, 32'hFFFF_FF00, 0);
        apb(1, CMF_PATTERN_OFS, 32'h5A, 0);
        send({8'h0, 32'h0, seed, 32'h5A});
        chk({32'h0, rx_irq}, 33'h1);
        apb(0, CMF_RX_FLAG_OFS, 0, 33'h1);
        apb(0, 8'h24, 0, {1'b0, seed});
        apb(1, CMF_RX_FLAG_OFS, 32'h1, 0);
        ok <= 0;
        send(104'h5A);
        ok <= 1;
        apb(0, CMF_RX_FLAG_OFS, 0, 33'h0);
        apb(1, CMF_CTRL_OFS, 32'h14, 0);
        apb(1, CMF_MASK_OFS, 32'h0, 0);
        apb(1, CMF_PATTERN_OFS, 32'h5A33_2211, 0);
        repeat (3) send(104'h5A);
        apb(0, CMF_RX_FLAG_OFS, 0, 33'h33);
        chk({32'h0, err_irq}, 33'h1);
        $display("receive and filter test done");
        apb(1, 8'h50, 32'h30, 0);
        apb(1, 8'h70, 32'h10, 0);
        apb(1, 8'h90, 32'h20, 0);
        seed = xs(seed);
        apb(1, 8'h60, seed, 0);
        apb(1, CMF_TX_FLAG_OFS, 32'h7, 0);
        eng_arb_req <= 1;
        tbi <= 4'h1;
        @(posedge pclk);
        eng_arb_req <= 0;
        repeat (2) @(posedge pclk);
        chk({30'h0, tx_pending, tx_buf_sel}, 33'h5);
        chk({25'h0, tx_byte}, {25'h0, seed[15:8]});
        apb(1, CMF_RX_FLAG_OFS, 32'h3, 0);
        send(104'h5A);
        apb(1, CMF_RX_FLAG_OFS, 32'h1, 0);
        apb(0, CMF_RX_FLAG_OFS, 0, 33'h30);
        eng_tx_done <= 1;
        @(posedge pclk);
        eng_tx_done <= 0;
        repeat (2) @(posedge pclk);
        apb(0, CMF_TX_FLAG_OFS, 0, 33'h2);
        apb(1, CMF_TX_CTRL_OFS, 32'h71, 0);
        apb(0, CMF_TX_FLAG_OFS, 0, 33'h13);
        eng_tx_dominant <= 1;
        repeat (3) @(posedge pclk);
        chk({32'h0, bus_tx_pin}, 33'h0);
        chk({32'h0, rx_dom}, 33'h1);
        chk({32'h0, tx_irq}, 33'h1);
        $display("transmit test done");
        end_of_test();
    end
endmodule
